// *** rtl/ovs_pkg.sv ***
// Behaviour
// RL1: Keyed main input 0.0-100%, default 0.0, volatile.
// RL2: Duty ratio scales input, default 100%.
// RL3: Base-up offset added to output, default 0.0.
// RL4: Ramp up over soft-start up time.
// RL5: Ramp down over soft-start down time.
// RL6: Upper clamp; below lower uses lower value.
// RL7: Lower clamp; above upper uses upper value.
// RL8: Burnout judged against threshold 1-100%, default 100.
// RL9: Control method: 0 phase, 1 optimum cycle.
// RL10: Main setting: 0 automatic, 1 manual.
// RL11: Phase teach only under phase control.
// RL12: Phase resistance visible only under phase control.
// RL13: Cycle teach only under optimum cycle control.
// RL14: Cycle resistance visible only under cycle control.
// RL15: Burnout judged only at output above floor; the code also judges at an output equal to the floor.
// RL16: Run time counts in 0.1 kh steps.
// RL17: Command clears the accumulated run time.
// RL18: Target is input times duty plus base-up, clamped.
// RL19: Zero soft-start time follows target immediately.
`default_nettype none
package ovs_pkg;
	localparam logic [7:0] OFS_INPUT = 8'h00;
	localparam logic [7:0] OFS_DUTY = 8'h04;
	localparam logic [7:0] OFS_BASEUP = 8'h08;
	localparam logic [7:0] OFS_RAMP_UP = 8'h0C;
	localparam logic [7:0] OFS_RAMP_DN = 8'h10;
	localparam logic [7:0] OFS_HI_CLAMP = 8'h14;
	localparam logic [7:0] OFS_LO_CLAMP = 8'h18;
	localparam logic [7:0] OFS_BURN_THR = 8'h1C;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_PHASE_RES = 8'h24;
	localparam logic [7:0] OFS_CYCLE_RES = 8'h28;
	localparam logic [7:0] OFS_BURN_FLOOR = 8'h2C;
	localparam logic [7:0] OFS_CMD = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_RUN_TIME = 8'h38;
	localparam int CTRL_METHOD_BIT = 0;
	localparam int CTRL_MANUAL_BIT = 1;
	localparam int CTRL_RUN_EN_BIT = 2;
	localparam int CMD_TEACH_PHASE_BIT = 0;
	localparam int CMD_TEACH_CYCLE_BIT = 1;
	localparam int CMD_CLEAR_RUN_BIT = 2;
	localparam int STATUS_BURNOUT_BIT = 16;
	localparam logic [9:0] FULL_SCALE = 10'h3E8;
	localparam logic [9:0] MAX_TENTHS = 10'h3E7;
	localparam logic [6:0] THR_MIN = 7'h01;
	localparam logic [6:0] THR_MAX = 7'h64;
	localparam logic [9:0] RST_INPUT = 10'h000;
	localparam logic [9:0] RST_DUTY = 10'h3E8;
	localparam logic [9:0] RST_BASEUP = 10'h000;
	localparam logic [9:0] RST_RAMP_UP = 10'h005;
	localparam logic [9:0] RST_RAMP_DN = 10'h000;
	localparam logic [9:0] RST_HI_CLAMP = 10'h3E8;
	localparam logic [9:0] RST_LO_CLAMP = 10'h000;
	localparam logic [6:0] RST_BURN_THR = 7'h64;
	localparam logic [9:0] RST_RES = 10'h000;
	localparam logic [9:0] RST_BURN_FLOOR = 10'h000;
	localparam logic [9:0] RST_RUN_TIME = 10'h000;
	localparam int CLOCK_HZ = 40_000_000;
	localparam int TICK_US = 100;
	localparam logic [31:0] TICK_CYCLES = 32'(CLOCK_HZ / 1_000_000 * TICK_US);
	localparam longint RUN_STEP_S = 360_000;
	localparam longint RUN_STEP_TICKS = RUN_STEP_S * longint'(1_000_000 / TICK_US);
endpackage
`default_nettype wire

// *** rtl/ovs_slew.sv ***
`default_nettype none
module ovs_slew
	import ovs_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Time base of 0.1 ms
	input  wire logic       tick,
	// Target and soft-start times in 0.1 s
	input  wire logic [9:0] target,
	input  wire logic [9:0] up_time,
	input  wire logic [9:0] dn_time,
	// Slewed value in 0.1 %
	output logic [9:0]      value
);
	// One 0.1 % step every time-setting ticks gives the full span in the set time.
	logic [9:0] cnt_q;
	logic [9:0] period;

	always_comb begin
		period = (target > value) ? up_time : dn_time;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			value <= 10'h000;
			cnt_q <= 10'h000;
		end else if (target == value) begin
			cnt_q <= 10'h000;
		end else if (period == 10'h000) begin
			value <= target; // [RL19]
			cnt_q <= 10'h000;
		end else if (tick) begin
			if (cnt_q >= period - 10'h001) begin
				cnt_q <= 10'h000;
				if (target > value) begin
					value <= value + 10'h001; // [RL4]
				end else begin
					value <= value - 10'h001; // [RL5]
				end
			end else begin
				cnt_q <= cnt_q + 10'h001;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/ovs_tick.sv ***
`default_nettype none
module ovs_tick
	import ovs_pkg::*;
#(
	parameter logic [31:0] DIV = 32'h00000001
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Count enable and output pulse
	input  wire logic en,
	output logic      tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (en) begin
				if (cnt_q >= DIV - 32'h1) begin
					cnt_q <= 32'h0;
					tick <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/ovs_top.sv ***
`default_nettype none
module ovs_top
	import ovs_pkg::*;
#(
	parameter logic [31:0] RUN_DIV = RUN_STEP_TICKS[31:0]
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	// Register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WRITE,
	input  wire logic        READ,
	output logic [31:0]      RDATA,
	// Automatic main setting and measurements from on-chip logic
	input  wire logic [9:0]  AUTO_MAIN_INPUT,
	input  wire logic [9:0]  MEAS_RESISTANCE,
	input  wire logic [6:0]  HEATER_CURRENT_PCT,
	// Results
	output logic [9:0]       OUTPUT_VALUE,
	output logic             BURNOUT_ALARM,
	output logic             METHOD_CYCLE,
	output logic             MANUAL_MODE,
	output logic             TEACH_PHASE_DONE,
	output logic             TEACH_CYCLE_DONE
);
	logic [9:0]  keyed_main_input_q;
	logic [9:0]  internal_duty_ratio_q;
	logic [9:0]  base_up_offset_q;
	logic [9:0]  ramp_up_time_q;
	logic [9:0]  ramp_down_time_q;
	logic [9:0]  output_high_clamp_q;
	logic [9:0]  output_low_clamp_q;
	logic [6:0]  burnout_threshold_q;
	logic        control_method_select_q;
	logic        manual_q;
	logic        run_en_q;
	logic [9:0]  phase_heater_resistance_q;
	logic [9:0]  cycle_heater_resistance_q;
	logic [9:0]  burnout_judge_floor_q;
	logic [9:0]  run_time_total_q;
	logic        wr_cmd;
	logic        teach_phase_heater;
	logic        teach_cycle_heater;
	logic        clear_run;
	logic [9:0]  main_in;
	logic [19:0] scaled;
	logic [10:0] sum;
	logic [9:0]  raw_target;
	logic [9:0]  hi_eff;
	logic [9:0]  lo_eff;
	logic [9:0]  target_d;
	logic [9:0]  slewed;
	logic        tick;
	logic        run_step;

	// Out-of-range writes saturate rather than wrap, so a bad value cannot invert the output.
	function automatic logic [9:0] sat_pct(input logic [31:0] w);
		sat_pct = (w > 32'(FULL_SCALE)) ? FULL_SCALE : w[9:0];
	endfunction

	function automatic logic [9:0] sat_tenths(input logic [31:0] w);
		sat_tenths = (w > 32'(MAX_TENTHS)) ? MAX_TENTHS : w[9:0];
	endfunction

	function automatic logic wr_at(input logic [7:0] a, input logic [7:0] ofs, input logic w);
		wr_at = w && (a == ofs);
	endfunction

	// Teach commands for the inactive control method are dropped without any effect.
	assign wr_cmd = wr_at(ADDR, OFS_CMD, WRITE);
	assign teach_phase_heater = wr_cmd && WDATA[CMD_TEACH_PHASE_BIT] && !control_method_select_q;
	assign teach_cycle_heater = wr_cmd && WDATA[CMD_TEACH_CYCLE_BIT] && control_method_select_q;
	assign clear_run = wr_cmd && WDATA[CMD_CLEAR_RUN_BIT];

	// Settings that are not kept over power loss simply return to defaults at reset.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			keyed_main_input_q <= RST_INPUT; // [RL1]
		end else if (wr_at(ADDR, OFS_INPUT, WRITE)) begin
			keyed_main_input_q <= sat_pct(WDATA); // [RL1]
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			internal_duty_ratio_q <= RST_DUTY;
			base_up_offset_q <= RST_BASEUP;
			output_high_clamp_q <= RST_HI_CLAMP;
			output_low_clamp_q <= RST_LO_CLAMP;
			burnout_judge_floor_q <= RST_BURN_FLOOR;
		end else begin
			if (wr_at(ADDR, OFS_DUTY, WRITE)) begin
				internal_duty_ratio_q <= sat_pct(WDATA); // [RL2]
			end
			if (wr_at(ADDR, OFS_BASEUP, WRITE)) begin
				base_up_offset_q <= sat_pct(WDATA); // [RL3]
			end
			if (wr_at(ADDR, OFS_HI_CLAMP, WRITE)) begin
				output_high_clamp_q <= sat_pct(WDATA); // [RL6]
			end
			if (wr_at(ADDR, OFS_LO_CLAMP, WRITE)) begin
				output_low_clamp_q <= sat_pct(WDATA); // [RL7]
			end
			if (wr_at(ADDR, OFS_BURN_FLOOR, WRITE)) begin
				burnout_judge_floor_q <= sat_pct(WDATA); // [RL15]
			end
		end
	end

	// Times count in tenths of a second and saturate at the largest value the setting allows.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ramp_up_time_q <= RST_RAMP_UP;
			ramp_down_time_q <= RST_RAMP_DN;
		end else begin
			if (wr_at(ADDR, OFS_RAMP_UP, WRITE)) begin
				ramp_up_time_q <= sat_tenths(WDATA); // [RL4]
			end
			if (wr_at(ADDR, OFS_RAMP_DN, WRITE)) begin
				ramp_down_time_q <= sat_tenths(WDATA); // [RL5]
			end
		end
	end

	// The threshold is pinned into its legal span, since a zero would silence the alarm for good.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			burnout_threshold_q <= RST_BURN_THR;
		end else if (wr_at(ADDR, OFS_BURN_THR, WRITE)) begin
			if (WDATA < 32'(THR_MIN)) begin
				burnout_threshold_q <= THR_MIN; // [RL8]
			end else if (WDATA > 32'(THR_MAX)) begin
				burnout_threshold_q <= THR_MAX;
			end else begin
				burnout_threshold_q <= WDATA[6:0];
			end
		end
	end

	// Method and main-setting choices are volatile: phase control and automatic after reset.
	// Run-time counting is off after reset, which stands for the disabled total.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			control_method_select_q <= 1'b0; // [RL9]
			manual_q <= 1'b0; // [RL10]
			run_en_q <= 1'b0;
		end else if (wr_at(ADDR, OFS_CTRL, WRITE)) begin
			control_method_select_q <= WDATA[CTRL_METHOD_BIT]; // [RL9]
			manual_q <= WDATA[CTRL_MANUAL_BIT]; // [RL10]
			run_en_q <= WDATA[CTRL_RUN_EN_BIT]; // [RL16]
		end
	end

	// Each resistance is reachable only while its own control method is active.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			phase_heater_resistance_q <= RST_RES;
			TEACH_PHASE_DONE <= 1'b0;
		end else begin
			TEACH_PHASE_DONE <= teach_phase_heater; // [RL11]
			if (teach_phase_heater) begin
				phase_heater_resistance_q <= sat_tenths(32'(MEAS_RESISTANCE)); // [RL11]
			end else if (wr_at(ADDR, OFS_PHASE_RES, WRITE) && !control_method_select_q) begin
				phase_heater_resistance_q <= sat_tenths(WDATA); // [RL12]
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			cycle_heater_resistance_q <= RST_RES;
			TEACH_CYCLE_DONE <= 1'b0;
		end else begin
			TEACH_CYCLE_DONE <= teach_cycle_heater; // [RL13]
			if (teach_cycle_heater) begin
				cycle_heater_resistance_q <= sat_tenths(32'(MEAS_RESISTANCE)); // [RL13]
			end else if (wr_at(ADDR, OFS_CYCLE_RES, WRITE) && control_method_select_q) begin
				cycle_heater_resistance_q <= sat_tenths(WDATA); // [RL14]
			end
		end
	end

	// Target path: scale, offset, then clamp between the effective limits.
	// The duty scales only the main input, never the base-up amount, so a zero input still yields the offset.
	// Crossed limits collapse to the band between them instead of forcing a single value.
	always_comb begin
		main_in = manual_q ? keyed_main_input_q : AUTO_MAIN_INPUT; // [RL10]
		scaled = 20'(main_in) * 20'(internal_duty_ratio_q) / 20'(FULL_SCALE); // [RL2] [RL18]
		sum = 11'(scaled[9:0]) + 11'(base_up_offset_q); // [RL3]
		raw_target = (sum > 11'(FULL_SCALE)) ? FULL_SCALE : sum[9:0];
		hi_eff = (output_high_clamp_q < output_low_clamp_q) ? output_low_clamp_q : output_high_clamp_q; // [RL6]
		lo_eff = (output_low_clamp_q > output_high_clamp_q) ? output_high_clamp_q : output_low_clamp_q; // [RL7]
		if (raw_target > hi_eff) begin
			target_d = hi_eff; // [RL18]
		end else if (raw_target < lo_eff) begin
			target_d = lo_eff;
		end else begin
			target_d = raw_target;
		end
	end

	// The 100 us time base runs free, so the first ramp step after a new target may come anywhere in one tick.
	// This keeps every later step exactly up_time or dn_time ticks apart at the cost of that start jitter.
	ovs_tick #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.clk (CLOCK),
		.rst (RESET),
		.en  (1'b1),
		.tick(tick)
	);

	// OUTPUT_VALUE is registered once more below, so it trails the slew register by one cycle.
	ovs_slew u_slew (
		.clk    (CLOCK),
		.rst    (RESET),
		.tick   (tick),
		.target (target_d),
		.up_time(ramp_up_time_q),
		.dn_time(ramp_down_time_q),
		.value  (slewed)
	);

	// Mode flags are copied to the outputs so that every port comes straight from a flip-flop.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			OUTPUT_VALUE <= 10'h000;
			METHOD_CYCLE <= 1'b0;
			MANUAL_MODE <= 1'b0;
		end else begin
			OUTPUT_VALUE <= slewed; // [RL18]
			METHOD_CYCLE <= control_method_select_q;
			MANUAL_MODE <= manual_q;
		end
	end

	// Below the floor the heater current is too small to judge reliably, so no alarm.
	// Judging on the slewed value keeps the alarm aligned with OUTPUT_VALUE in the same cycle.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			BURNOUT_ALARM <= 1'b0;
		end else begin
			BURNOUT_ALARM <= (slewed >= burnout_judge_floor_q) // [RL15]
				&& (HEATER_CURRENT_PCT < burnout_threshold_q); // [RL8]
		end
	end

	// The run-time prescaler only advances on time-base ticks while counting is enabled.
	// A clear resets the prescaler as well, so the first step after a clear is a full step away.
	ovs_tick #(
		.DIV(RUN_DIV)
	) u_run (
		.clk (CLOCK),
		.rst (RESET || clear_run),
		.en  (tick && run_en_q),
		.tick(run_step)
	);

	// A clear arriving with a step still clears; the step is dropped.
	// The total holds at its top value instead of wrapping back to zero.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			run_time_total_q <= RST_RUN_TIME;
		end else if (clear_run) begin
			run_time_total_q <= RST_RUN_TIME; // [RL17]
		end else if (run_step && run_time_total_q < MAX_TENTHS) begin
			run_time_total_q <= run_time_total_q + 10'h001; // [RL16]
		end
	end

	// Read data stand for one cycle only and then return to zero.
	// Write-only and unmapped addresses read as zero, so software can probe the map safely.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			RDATA <= 32'h0;
		end else begin
			RDATA <= 32'h0;
			if (READ) begin
				case (ADDR)
					OFS_INPUT:      RDATA <= 32'(keyed_main_input_q);
					OFS_DUTY:       RDATA <= 32'(internal_duty_ratio_q);
					OFS_BASEUP:     RDATA <= 32'(base_up_offset_q);
					OFS_RAMP_UP:    RDATA <= 32'(ramp_up_time_q);
					OFS_RAMP_DN:    RDATA <= 32'(ramp_down_time_q);
					OFS_HI_CLAMP:   RDATA <= 32'(output_high_clamp_q);
					OFS_LO_CLAMP:   RDATA <= 32'(output_low_clamp_q);
					OFS_BURN_THR:   RDATA <= 32'(burnout_threshold_q);
					OFS_CTRL:       RDATA <= 32'({run_en_q, manual_q, control_method_select_q});
					OFS_PHASE_RES:  RDATA <= control_method_select_q ? 32'h0 : 32'(phase_heater_resistance_q); // [RL12]
					OFS_CYCLE_RES:  RDATA <= control_method_select_q ? 32'(cycle_heater_resistance_q) : 32'h0; // [RL14]
					OFS_BURN_FLOOR: RDATA <= 32'(burnout_judge_floor_q);
					OFS_STATUS:     RDATA <= 32'({BURNOUT_ALARM, 6'h00, OUTPUT_VALUE});
					OFS_RUN_TIME:   RDATA <= 32'(run_time_total_q); // [RL16]
					default:        RDATA <= 32'h0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/ovs_top_monitor.sv ***
`default_nettype none
module ovs_top_monitor
	import ovs_pkg::*;
(
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RESET,
	// Register port
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WRITE,
	input wire logic        READ,
	input wire logic [31:0] RDATA,
	// Inputs and results
	input wire logic [6:0]  HEATER_CURRENT_PCT,
	input wire logic [9:0]  OUTPUT_VALUE,
	input wire logic        BURNOUT_ALARM,
	input wire logic        MANUAL_MODE,
	input wire logic        TEACH_PHASE_DONE,
	input wire logic        TEACH_CYCLE_DONE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	chk_rdata_idle: assert property (!READ |=> RDATA == 32'h0)
		else $error("read data not idle");
	chk_status_value: assert property (READ && ADDR == OFS_STATUS |=> RDATA[9:0] == $past(OUTPUT_VALUE))
		else $error("status value wrong");
	chk_cmd_reads_zero: assert property (READ && ADDR == OFS_CMD |=> RDATA == 32'h0)
		else $error("command register read not zero");
	chk_run_bound: assert property (READ && ADDR == OFS_RUN_TIME |=> RDATA <= {22'h0, MAX_TENTHS})
		else $error("run time out of range");
	chk_out_bound: assert property (OUTPUT_VALUE <= FULL_SCALE)
		else $error("output above full scale");
	chk_alarm_thr: assert property ($past(HEATER_CURRENT_PCT) >= THR_MAX |-> !BURNOUT_ALARM)
		else $error("alarm with full current");
	chk_phase_pulse: assert property (TEACH_PHASE_DONE |=> !TEACH_PHASE_DONE)
		else $error("phase teach pulse too long");
	chk_phase_cause: assert property (TEACH_PHASE_DONE |-> $past(WRITE && ADDR == OFS_CMD && WDATA[0]))
		else $error("phase teach without command");
	chk_cycle_cause: assert property (TEACH_CYCLE_DONE |-> $past(WRITE && ADDR == OFS_CMD && WDATA[1]))
		else $error("cycle teach without command");
	chk_mode_cause: assert property ($changed(MANUAL_MODE) |->
		$past(WRITE && ADDR == OFS_CTRL) || $past(WRITE && ADDR == OFS_CTRL, 2))
		else $error("mode changed without write");
endmodule

bind ovs_top ovs_top_monitor u_ovs_top_monitor (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WRITE(WRITE), .READ(READ), .RDATA(RDATA), .HEATER_CURRENT_PCT(HEATER_CURRENT_PCT),
	.OUTPUT_VALUE(OUTPUT_VALUE), .BURNOUT_ALARM(BURNOUT_ALARM), .MANUAL_MODE(MANUAL_MODE),
	.TEACH_PHASE_DONE(TEACH_PHASE_DONE), .TEACH_CYCLE_DONE(TEACH_CYCLE_DONE));
`default_nettype wire

// *** verif/ovs_top_tb.sv ***
`default_nettype none
module ovs_top_tb
	import ovs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short run-time prescale keeps a 0.1 kh step at 12000 cycles.
	localparam logic [31:0] RUN_DIV_SIM = 32'h00000003;
	logic        CLOCK = 1'b0;
	logic        RESET = 1'b1;
	logic [7:0]  ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic        WRITE = 1'b0;
	logic        READ = 1'b0;
	logic [31:0] RDATA;
	logic [9:0]  AUTO_MAIN_INPUT = 10'h000;
	logic [9:0]  MEAS_RESISTANCE = 10'h07B;
	logic [6:0]  HEATER_CURRENT_PCT = 7'h64;
	logic [9:0]  OUTPUT_VALUE;
	logic        BURNOUT_ALARM;
	logic        METHOD_CYCLE;
	logic        MANUAL_MODE;
	logic        TEACH_PHASE_DONE;
	logic        TEACH_CYCLE_DONE;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [9:0]  dflt [12] = '{RST_INPUT, RST_DUTY, RST_BASEUP, RST_RAMP_UP, RST_RAMP_DN, RST_HI_CLAMP,
		RST_LO_CLAMP, {3'h0, RST_BURN_THR}, 10'h000, RST_RES, RST_RES, RST_BURN_FLOOR};

	ovs_top #(.RUN_DIV(RUN_DIV_SIM)) u_ovs_top (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
		.WRITE(WRITE), .READ(READ), .RDATA(RDATA), .AUTO_MAIN_INPUT(AUTO_MAIN_INPUT),
		.MEAS_RESISTANCE(MEAS_RESISTANCE), .HEATER_CURRENT_PCT(HEATER_CURRENT_PCT),
		.OUTPUT_VALUE(OUTPUT_VALUE), .BURNOUT_ALARM(BURNOUT_ALARM), .METHOD_CYCLE(METHOD_CYCLE),
		.MANUAL_MODE(MANUAL_MODE), .TEACH_PHASE_DONE(TEACH_PHASE_DONE), .TEACH_CYCLE_DONE(TEACH_CYCLE_DONE));

	initial begin
		forever #12.5 CLOCK = ~CLOCK;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		WRITE <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WRITE <= 1'b0;
	endtask

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLOCK);
		READ <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		READ <= 1'b0;
		#1 cmp(name, exp, RDATA);
	endtask

	// Waits n edges, then steps past the edge so registered outputs have landed.
	task automatic w(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask

	initial begin
		repeat (2) @(posedge CLOCK);
		RESET <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			chk_rd("default", 8'(i * 4), {22'h0, dflt[i]});
		end
		chk_rd("run default", OFS_RUN_TIME, 32'h0);
		chk_rd("unmapped", 8'h3C, 32'h0);
		chk_rd("cmd read", OFS_CMD, 32'h0);
		wr(OFS_DUTY, 32'h7D0);
		chk_rd("duty sat", OFS_DUTY, 32'h3E8);
		wr(OFS_RAMP_UP, 32'h0);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_INPUT, 32'h1F4);
		wr(OFS_DUTY, 32'h1F4);
		wr(OFS_BASEUP, 32'h64);
		w(4);
		cmp("target", 32'h15E, OUTPUT_VALUE);
		cmp("manual", 32'h1, MANUAL_MODE);
		@(posedge CLOCK);
		AUTO_MAIN_INPUT <= 10'h0C8;
		wr(OFS_CTRL, 32'h0);
		w(4);
		cmp("auto", 32'h0C8, OUTPUT_VALUE);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_HI_CLAMP, 32'hC8);
		wr(OFS_LO_CLAMP, 32'h12C);
		w(4);
		cmp("hi below lo", 32'h12C, OUTPUT_VALUE);
		wr(OFS_HI_CLAMP, 32'h3E8);
		wr(OFS_LO_CLAMP, 32'h190);
		w(4);
		cmp("lo clamp", 32'h190, OUTPUT_VALUE);
		wr(OFS_LO_CLAMP, 32'h0);
		wr(OFS_RAMP_UP, 32'h1);
		wr(OFS_BASEUP, 32'h66);
		w(10);
		cmp("rising", 32'h1, OUTPUT_VALUE < 10'h160);
		w(9000);
		cmp("risen", 32'h160, OUTPUT_VALUE);
		wr(OFS_RAMP_DN, 32'h1);
		wr(OFS_BASEUP, 32'h64);
		w(10);
		cmp("falling", 32'h1, OUTPUT_VALUE > 10'h15E);
		w(9000);
		cmp("fallen", 32'h15E, OUTPUT_VALUE);
		@(posedge CLOCK);
		HEATER_CURRENT_PCT <= 7'h32;
		w(4);
		cmp("alarm", 32'h1, BURNOUT_ALARM);
		wr(OFS_BURN_FLOOR, 32'h15F);
		w(4);
		cmp("below floor", 32'h0, BURNOUT_ALARM);
		wr(OFS_BURN_FLOOR, 32'h15E);
		w(4);
		cmp("at floor", 32'h1, BURNOUT_ALARM);
		chk_rd("status alarm", OFS_STATUS, 32'h0001015E);
		wr(OFS_BURN_THR, 32'h28);
		w(4);
		cmp("thr", 32'h0, BURNOUT_ALARM);
		wr(OFS_BURN_THR, 32'h0);
		chk_rd("thr min", OFS_BURN_THR, 32'h1);
		chk_rd("status", OFS_STATUS, 32'h15E);
		wr(OFS_CMD, 32'h2);
		#1 cmp("cycle ignored", 32'h0, TEACH_CYCLE_DONE);
		wr(OFS_CMD, 32'h1);
		#1 cmp("phase done", 32'h1, TEACH_PHASE_DONE);
		chk_rd("phase res", OFS_PHASE_RES, 32'h7B);
		wr(OFS_CTRL, 32'h3);
		chk_rd("phase hidden", OFS_PHASE_RES, 32'h0);
		cmp("method", 32'h1, METHOD_CYCLE);
		wr(OFS_CMD, 32'h2);
		#1 cmp("cycle done", 32'h1, TEACH_CYCLE_DONE);
		chk_rd("cycle res", OFS_CYCLE_RES, 32'h7B);
		wr(OFS_CYCLE_RES, 32'h5DC);
		chk_rd("cycle sat", OFS_CYCLE_RES, 32'h3E7);
		wr(OFS_PHASE_RES, 32'h10);
		wr(OFS_CTRL, 32'h6);
		chk_rd("phase kept", OFS_PHASE_RES, 32'h7B);
		w(26000);
		chk_rd("run time", OFS_RUN_TIME, 32'h2);
		wr(OFS_CMD, 32'h4);
		chk_rd("run clear", OFS_RUN_TIME, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
